// >>> src/dca_color_pipe.sv
// Purpose: Color adjust datapath with APB registers, input table and dither
// Assumes: One pixel per clk_sys from capture logic on the same clock
// Notes: Settings act at once, software should change them in blanking
//
// What this block does
// RULE1 - Hue and saturation stage is off after reset, passing pixels unchanged.
// RULE2 - Chroma controls work for RGB graphics and CbCr video sources.
// RULE3 - Hue rotates the CbCr vector by a programmed angle, magnitude kept.
// RULE4 - Saturation multiplies Cb and Cr by the same gain.
// RULE5 - Cb and Cr outputs use programmed sat*cos and sat*sin terms.
// RULE6 - Luma out is (Y minus black) times contrast plus brightness.
// RULE7 - Programmed coefficients feed multipliers and adders as written.
// RULE8 - Flesh tone tweaks come from channel parameters, for all sources.
// RULE9 - RGB stage subtracts each channel's own black offset first.
// RULE10 - Each RGB channel: (in minus black) times gain plus offset.
// RULE11 - Brightness add saturates at 255.
// RULE12 - Input table follows RGB stage, host may enable or bypass it.
// RULE13 - Each channel has a 256 entry table giving 10-bit results.
// RULE14 - Host writes one channel's table alone or all three together.
// RULE15 - 10-bit table output is dithered to 8 bits before leaving.
// RULE16 - Dither offers random and ordered patterns, host selectable.
// RULE17 - Black offset subtraction below zero clamps to zero.
// RULE18 - One pixel per clock, fixed latency, strobes delayed alike.

`timescale 1ns/1ns

module dca_color_pipe (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dca_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dca_pkg::dca_pix_type pix_in,
  output dca_pkg::dca_pix_type pix_out
);
  import dca_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [3:0] ctrl_ff;
  logic [31:0] coef_ff;
  logic [23:0] luma_ff;
  logic [23:0] adj_ff [0:2];
  logic [10:0] tidx_ff;
  logic [15:0] frame_cnt_ff;
  logic vs_d_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite & pready_ff;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_coef = paddr == ADDR_COEF;
  wire hit_luma = paddr == ADDR_LUMA;
  wire hit_red = paddr == ADDR_RED;
  wire hit_grn = paddr == ADDR_GRN;
  wire hit_blu = paddr == ADDR_BLU;
  wire hit_tidx = paddr == ADDR_TIDX;
  wire hit_tdat = paddr == ADDR_TDAT;
  wire hit_stat = paddr == ADDR_STAT;
  wire hit_any = hit_ctrl | hit_coef | hit_luma | hit_red | hit_grn | hit_blu |
                 hit_tidx | hit_tdat | hit_stat;
  wire tbl_we = wr_en & hit_tdat;

  wire chroma_en = ctrl_ff[CTRL_CHROMA_EN];
  wire src_ycc = ctrl_ff[CTRL_SRC_YCC];
  wire tbl_en = ctrl_ff[CTRL_TABLE_EN];
  wire ordered = ctrl_ff[CTRL_ORDERED];

  dca_pix_type out_ff;

  // Table data reads as zero, the table is write only
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl_ff} :
                       hit_coef ? coef_ff :
                       hit_luma ? {8'h0, luma_ff} :
                       hit_red ? {8'h0, adj_ff[0]} :
                       hit_grn ? {8'h0, adj_ff[1]} :
                       hit_blu ? {8'h0, adj_ff[2]} :
                       hit_tidx ? {21'h0, tidx_ff} :
                       hit_stat ? {15'h0, out_ff.de, frame_cnt_ff} :
                       32'h0;

  // ---------------------------------------------------------------
  // APB answer, always one wait-free access phase
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit_any;
      if (setup & ~pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST; // RULE1
      coef_ff <= COEF_RST;
      luma_ff <= ADJ_RST;
      for (int i = 0; i < 3; i++) begin
        adj_ff[i] <= ADJ_RST;
      end
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_ff <= pwdata[3:0];
      end
      if (hit_coef) begin
        coef_ff <= {6'h0, pwdata[25:16], 6'h0, pwdata[9:0]};
      end
      if (hit_luma) begin
        luma_ff <= pwdata[23:0];
      end
      if (hit_red) begin
        adj_ff[0] <= pwdata[23:0];
      end
      if (hit_grn) begin
        adj_ff[1] <= pwdata[23:0];
      end
      if (hit_blu) begin
        adj_ff[2] <= pwdata[23:0];
      end
    end
  end

  // Index steps after each data write so a table loads as a burst
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tidx_ff <= TIDX_RST;
    end else if (tbl_we) begin
      tidx_ff[7:0] <= tidx_ff[7:0] + 8'h01; // RULE14
    end else if (wr_en & hit_tidx) begin
      tidx_ff <= pwdata[10:0];
    end
  end

  // ---------------------------------------------------------------
  // Stage 1: capture, frame counter for status
  // ---------------------------------------------------------------
  dca_pix_type s1_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= '0;
      vs_d_ff <= 1'b0;
      frame_cnt_ff <= 16'h0;
    end else begin
      s1_ff <= pix_in; // RULE18
      vs_d_ff <= s1_ff.vs;
      if (s1_ff.vs & ~vs_d_ff) begin
        frame_cnt_ff <= frame_cnt_ff + 16'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stage 2: luma and chroma controls
  // ---------------------------------------------------------------
  dca_pix_type s2;

  dca_chroma u_chroma (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .enable(chroma_en), // RULE1
    .src_ycc(src_ycc), // RULE2
    .coef(dca_coef_type'({coef_ff[25:16], coef_ff[9:0]})), // RULE7
    .luma(dca_adj_type'(luma_ff)), // RULE7
    .pix_in(s1_ff),
    .pix_out(s2)
  );

  // ---------------------------------------------------------------
  // Stages 3 to 5: RGB controls, table, dither
  // ---------------------------------------------------------------
  // Strobe vectors hold de, hs, vs from high to low bit
  logic [2:0] s3_strb_ff;
  logic [2:0] s4_strb_ff;
  logic x_ff;
  logic y_ff;
  logic [15:0] lfsr_ff;
  logic [7:0] s2_ch [0:2];
  logic [7:0] chan_q [0:2];
  logic [9:0] t4_ff [0:2];
  logic [7:0] dith_w [0:2];

  assign s2_ch[0] = s2.c0;
  assign s2_ch[1] = s2.c1;
  assign s2_ch[2] = s2.c2;

  // Ordered pattern is a 2x2 matrix stepped by pixel and line parity
  wire [1:0] bayer = {x_ff ^ y_ff, y_ff}; // RULE16

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      logic [TBL_W-1:0] tbl_mem [0:TBL_DEPTH-1]; // RULE13

      dca_chan u_chan (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .adj(dca_adj_type'(adj_ff[ch])), // RULE7 RULE10
        .pix(s2_ch[ch]),
        .pix_q(chan_q[ch])
      );

      // Mask bit per channel, all set writes the three tables at once
      always_ff @(posedge clk_sys) begin
        if (tbl_we & tidx_ff[TIDX_MASK_LSB + ch]) begin
          tbl_mem[tidx_ff[7:0]] <= pwdata[TBL_W-1:0]; // RULE14
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          t4_ff[ch] <= 10'h0;
        end else begin
          t4_ff[ch] <= tbl_en ? tbl_mem[chan_q[ch]] : {chan_q[ch], 2'b00}; // RULE12 RULE13
        end
      end

      // Bypassed data has zero low bits, so the dither adds nothing to it
      wire [1:0] thr = ordered ? bayer : lfsr_ff[2*ch +: 2]; // RULE16
      wire [10:0] dsum = {1'b0, t4_ff[ch]} + {9'h0, thr}; // RULE15
      assign dith_w[ch] = dsum[10] ? PIX_MAX : dsum[9:2]; // RULE15
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s3_strb_ff <= 3'h0;
      s4_strb_ff <= 3'h0;
      out_ff <= '0;
      x_ff <= 1'b0;
      y_ff <= 1'b0;
      lfsr_ff <= LFSR_SEED;
    end else begin
      s3_strb_ff <= {s2.de, s2.hs, s2.vs}; // RULE18
      s4_strb_ff <= s3_strb_ff;
      out_ff.de <= s4_strb_ff[2];
      out_ff.hs <= s4_strb_ff[1];
      out_ff.vs <= s4_strb_ff[0];
      out_ff.c0 <= dith_w[0];
      out_ff.c1 <= dith_w[1];
      out_ff.c2 <= dith_w[2];
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]}; // RULE16
      x_ff <= s4_strb_ff[2] & ~x_ff;
      if (s4_strb_ff[0]) begin
        y_ff <= 1'b0;
      end else if (~s4_strb_ff[2] & out_ff.de) begin
        y_ff <= ~y_ff;
      end
    end
  end

  assign pix_out = out_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  pipe_latency_a: assert property ( // RULE18
    @(posedge clk_sys) disable iff (!reset_n)
    ##5 ({pix_out.de, pix_out.hs, pix_out.vs} == $past({pix_in.de, pix_in.hs, pix_in.vs}, 5)))
    else $error("strobes not delayed by pipeline latency");

  table_bypass_a: assert property ( // RULE12
    @(posedge clk_sys) disable iff (!reset_n)
    !tbl_en [*2] |=> (pix_out.c0 == $past(chan_q[0], 2)))
    else $error("bypassed table changed pixel");

  dither_range_a: assert property ( // RULE15
    @(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> (8'(pix_out.c1 - $past(t4_ff[1][9:2])) <= 8'h01))
    else $error("dithered value off truncated table output");

  ordered_step_a: assert property ( // RULE16
    @(posedge clk_sys) disable iff (!reset_n)
    (ordered && x_ff && !y_ff && t4_ff[2][1:0] == 2'b10 && t4_ff[2][9:2] != PIX_MAX)
    |=> (pix_out.c2 == $past(t4_ff[2][9:2]) + 8'h01))
    else $error("ordered dither threshold wrong");

  table_bcast_a: assert property ( // RULE14
    @(posedge clk_sys) disable iff (!reset_n)
    (tbl_we && tidx_ff[10:8] == 3'b111)
    |=> (g_ch[0].tbl_mem[$past(tidx_ff[7:0])] == $past(pwdata[9:0]) &&
         g_ch[2].tbl_mem[$past(tidx_ff[7:0])] == $past(pwdata[9:0])))
    else $error("broadcast table write missed a channel");

  apb_answer_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (psel && !penable) |=> (pready && pslverr == !$past(hit_any)))
    else $error("access phase answer wrong");

endmodule // dca_color_pipe

// >>> src/dca_pkg.sv
// Purpose: Shared constants, types and helpers of the color adjust pipeline
// Assumes: 8-bit pixels per channel, APB register access, one clock
// Notes: Gains are 2.6 unsigned, chroma terms are signed 2.8

package dca_pkg;

  // ---------------------------------------------------------------
  // Widths and formats
  // ---------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam int TBL_W = 10;
  localparam int TBL_DEPTH = 256;
  localparam int GAIN_FRAC = 6;
  localparam int COEF_FRAC = 8;
  localparam int LATENCY = 5;
  localparam logic [7:0] CHROMA_MID = 8'h80;
  localparam logic [7:0] PIX_MAX = 8'hff;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COEF = 8'h04;
  localparam logic [7:0] ADDR_LUMA = 8'h08;
  localparam logic [7:0] ADDR_RED = 8'h0c;
  localparam logic [7:0] ADDR_GRN = 8'h10;
  localparam logic [7:0] ADDR_BLU = 8'h14;
  localparam logic [7:0] ADDR_TIDX = 8'h18;
  localparam logic [7:0] ADDR_TDAT = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;

  localparam int CTRL_CHROMA_EN = 0;
  localparam int CTRL_SRC_YCC = 1;
  localparam int CTRL_TABLE_EN = 2;
  localparam int CTRL_ORDERED = 3;
  localparam int TIDX_MASK_LSB = 8;

  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [31:0] COEF_RST = 32'h0000_0100;
  localparam logic [23:0] ADJ_RST = 24'h00_40_00;
  localparam logic [10:0] TIDX_RST = 11'h700;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } dca_pix_type;

  typedef struct packed {
    logic [7:0] add;
    logic [7:0] gain;
    logic [7:0] black;
  } dca_adj_type;

  typedef struct packed {
    logic signed [9:0] sat_sin;
    logic signed [9:0] sat_cos;
  } dca_coef_type;

  function automatic logic [7:0] dca_sat8(input logic signed [19:0] v);
    if (v < 0) return 8'h00;
    if (v > 20'sd255) return PIX_MAX;
    return v[7:0];
  endfunction

endpackage

// >>> src/dca_chan.sv
// Purpose: One RGB channel: black offset, contrast gain, brightness add
// Assumes: Gain in 2.6 format, one registered stage
// Notes: Brightness saturates at full scale

`timescale 1ns/1ns

module dca_chan (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire dca_pkg::dca_adj_type adj,
  input wire logic [7:0] pix,
  output logic [7:0] pix_q
);
  import dca_pkg::*;

  wire [7:0] lifted = (pix > adj.black) ? 8'(pix - adj.black) : 8'h00; // RULE9 RULE17
  wire [15:0] scaled = lifted * adj.gain; // RULE10
  wire [19:0] summed = {4'h0, 6'h0, scaled[15:GAIN_FRAC]} + {12'h0, adj.add}; // RULE11

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pix_q <= 8'h00;
    end else begin
      pix_q <= dca_sat8($signed(summed)); // RULE11
    end
  end

  black_clamp_a: assert property ( // RULE17
    @(posedge clk_sys) disable iff (!reset_n)
    (pix <= adj.black) |=> (pix_q == $past(adj.add)))
    else $error("pixel under black level not clamped");

  bright_sat_a: assert property ( // RULE11
    @(posedge clk_sys) disable iff (!reset_n)
    (adj.add == PIX_MAX) |=> (pix_q == PIX_MAX))
    else $error("brightness did not saturate at full scale");

endmodule // dca_chan

// >>> src/dca_chroma.sv
// Purpose: Luma black/contrast/brightness and chroma hue/saturation stage
// Assumes: YCbCr in offset binary or RGB; RGB goes through a cheap YCbCr split
// Notes: Disabled stage passes pixels untouched, one registered stage

`timescale 1ns/1ns

module dca_chroma (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic src_ycc,
  input wire dca_pkg::dca_coef_type coef,
  input wire dca_pkg::dca_adj_type luma,
  input wire dca_pkg::dca_pix_type pix_in,
  output dca_pkg::dca_pix_type pix_out
);
  import dca_pkg::*;

  // Y = (R + 2G + B) / 4, Cb = B - Y, Cr = R - Y for graphics sources
  wire [9:0] y_sum = {2'b0, pix_in.c0} + {1'b0, pix_in.c1, 1'b0} + {2'b0, pix_in.c2};
  wire [7:0] y8 = src_ycc ? pix_in.c0 : y_sum[9:2]; // RULE2
  wire signed [9:0] cb = src_ycc ? $signed({2'b0, pix_in.c1}) - $signed({2'b0, CHROMA_MID})
                                 : $signed({2'b0, pix_in.c2}) - $signed({2'b0, y8});
  wire signed [9:0] cr = src_ycc ? $signed({2'b0, pix_in.c2}) - $signed({2'b0, CHROMA_MID})
                                 : $signed({2'b0, pix_in.c0}) - $signed({2'b0, y8});

  wire [7:0] y_lift = (y8 > luma.black) ? 8'(y8 - luma.black) : 8'h00; // RULE6 RULE17
  wire [15:0] y_scl = y_lift * luma.gain; // RULE6
  wire [7:0] y_out = dca_sat8($signed({10'h0, y_scl[15:GAIN_FRAC]} + {12'h0, luma.add})); // RULE6

  // Programmed terms go straight into the products
  wire signed [20:0] cb_p = 21'(cb * coef.sat_cos) + 21'(cr * coef.sat_sin); // RULE3 RULE4 RULE5 RULE7
  wire signed [20:0] cr_p = 21'(cr * coef.sat_cos) - 21'(cb * coef.sat_sin); // RULE3 RULE4 RULE5 RULE7
  wire signed [19:0] cb_o = 20'(cb_p >>> COEF_FRAC);
  wire signed [19:0] cr_o = 20'(cr_p >>> COEF_FRAC);
  wire signed [19:0] y_s = $signed({12'h0, y_out});
  wire signed [19:0] mid = $signed({12'h0, CHROMA_MID});
  wire signed [19:0] half = (cb_o + cr_o) >>> 1;

  dca_pix_type adj_pix;
  assign adj_pix.de = pix_in.de;
  assign adj_pix.hs = pix_in.hs;
  assign adj_pix.vs = pix_in.vs;
  assign adj_pix.c0 = src_ycc ? y_out : dca_sat8(y_s + cr_o); // RULE2 RULE8
  assign adj_pix.c1 = src_ycc ? dca_sat8(cb_o + mid) : dca_sat8(y_s - half);
  assign adj_pix.c2 = src_ycc ? dca_sat8(cr_o + mid) : dca_sat8(y_s + cb_o);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pix_out <= '0;
    end else begin
      pix_out <= enable ? adj_pix : pix_in; // RULE1
    end
  end

  chroma_bypass_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (!reset_n)
    !enable |=> (pix_out == $past(pix_in)))
    else $error("disabled chroma stage altered pixel");

  sat_zero_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!reset_n)
    (enable && src_ycc && coef == '0) |=> (pix_out.c1 == CHROMA_MID && pix_out.c2 == CHROMA_MID))
    else $error("zero saturation left chroma nonzero");

endmodule // dca_chroma

// >>> tb/dca_pix_partner.sv
// Purpose: Capture-side pixel source facing the color adjust pipeline
// Assumes: One pixel per clock, no back pressure on either side
// Notes: The converter side only latches, so the bench samples pix_out

`timescale 1ns/1ns

module dca_pix_partner (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire dca_pkg::dca_pix_type pix_out,
  output dca_pkg::dca_pix_type pix_in
);
  import dca_pkg::*;

  // Drive just after a rising edge so the pipe samples it on the next one
  task automatic put(input dca_pix_type p, input int n);
    repeat (n) @(posedge clk_sys);
    pix_in <= p;
  endtask
endmodule // dca_pix_partner

// >>> tb/dca_color_pipe_test.sv
// Purpose: Self-checking bench for the color adjust pipeline
// Assumes: One-cycle APB access phase, five clock pixel latency
// Notes: Table memory is not reset, so only written entries are used

`timescale 1ns/1ns

module dca_color_pipe_test;
  import dca_pkg::*;

  logic clk_sys;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dca_pix_type pix_in;
  dca_pix_type pix_out;
  int err_count;
  int n_checks;
  logic [31:0] rd;
  logic er;

  dca_color_pipe dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_in(pix_in), .pix_out(pix_out));

  dca_pix_partner src (.clk_sys(clk_sys), .reset_n(reset_n), .pix_out(pix_out), .pix_in(pix_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, eexp});
  endtask

  function automatic dca_pix_type px(input logic de, input logic vs, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] c);
    return {de, 1'b0, vs, a, b, c};
  endfunction

  // Black clamp, 2.6 gain, saturating add
  function automatic logic [7:0] ch_exp(input int v, input int blk, input int g, input int add);
    int t;
    t = v - blk;
    if (t < 0) t = 0;
    t = ((t * g) >> 6) + add;
    return (t > 255) ? 8'hff : t[7:0];
  endfunction

  // Offset-binary chroma, 2.8 signed terms
  function automatic logic [7:0] cexp(input int a, input int b, input int c, input int s);
    int t;
    t = (((a - 128) * c + (b - 128) * s) >>> 8) + 128;
    return (t < 0) ? 8'h00 : (t > 255) ? 8'hff : t[7:0];
  endfunction

  // Holds the pixel until the pipe is full of it
  task automatic pix_chk(input dca_pix_type p, input dca_pix_type x);
    src.put(p, 1);
    repeat (7) @(posedge clk_sys);
    #1;
    chk({5'h00, pix_out}, {5'h00, x});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] a[8] = '{ADDR_CTRL, ADDR_COEF, ADDR_LUMA, ADDR_RED, ADDR_GRN, ADDR_BLU, ADDR_TIDX, ADDR_TDAT};
    logic [31:0] e[8] = '{32'h0, 32'h100, 32'h4000, 32'h4000, 32'h4000, 32'h4000, 32'h700, 32'h0};
    for (int i = 0; i < 8; i++) begin
      rchk(a[i], e[i], 1'b0);
    end
    wr(8'h24, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    rchk(8'h24, 32'h0, 1'b1);
  endtask

  task automatic t_latency();
    dca_pix_type p;
    p = px(1'b1, 1'b0, 8'h12, 8'h34, 8'h56);
    p.hs = 1'b1;
    src.put('0, 1);
    repeat (8) @(posedge clk_sys);
    src.put(p, 1);
    src.put('0, 1);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({5'h00, pix_out}, 32'h0);
    @(posedge clk_sys);
    #1;
    chk({5'h00, pix_out}, {5'h00, p});
    @(posedge clk_sys);
    #1;
    chk({5'h00, pix_out}, 32'h0);
  endtask

  task automatic t_rgb();
    dca_pix_type x;
    wr(ADDR_RED, 32'h0010_8020);
    wr(ADDR_GRN, 32'h0005_4040);
    wr(ADDR_BLU, 32'h00ff_4000);
    x = px(1'b1, 1'b0, ch_exp(80, 32, 128, 16), ch_exp(48, 64, 64, 5), ch_exp(80, 0, 64, 255));
    pix_chk(px(1'b1, 1'b0, 8'h50, 8'h30, 8'h50), x);
    wr(ADDR_RED, 32'h0000_4000);
    wr(ADDR_GRN, 32'h0000_4000);
    wr(ADDR_BLU, 32'h0000_4000);
  endtask

  task automatic t_chroma();
    int c[4] = '{181, 128, 300, 0};
    int s[4] = '{181, -128, 0, 0};
    dca_pix_type p;
    dca_pix_type x;
    p = px(1'b1, 1'b0, 8'h80, 8'ha0, 8'h50);
    wr(ADDR_LUMA, 32'h0008_6010);
    rchk(ADDR_LUMA, 32'h0008_6010, 1'b0);
    pix_chk(p, p);
    wr(ADDR_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_COEF, {6'h00, 10'(s[i]), 6'h00, 10'(c[i])});
      x = px(1'b1, 1'b0, ch_exp(128, 16, 96, 8), cexp(160, 80, c[i], s[i]), cexp(80, 160, c[i], -s[i]));
      pix_chk(p, x);
    end
    // Gray graphics carries no chroma, so any gain must leave it alone
    wr(ADDR_LUMA, 32'h0000_4000);
    wr(ADDR_COEF, 32'h0000_0080);
    wr(ADDR_CTRL, 32'h1);
    pix_chk(px(1'b1, 1'b0, 8'h40, 8'h40, 8'h40), px(1'b1, 1'b0, 8'h40, 8'h40, 8'h40));
    wr(ADDR_CTRL, 32'h0);
  endtask

  task automatic t_table();
    int hi;
    hi = 0;
    wr(ADDR_TIDX, 32'h0000_0710);
    wr(ADDR_TDAT, 32'h0000_0040);
    wr(ADDR_TIDX, 32'h0000_0110);
    wr(ADDR_TDAT, 32'h0000_03fc);
    wr(ADDR_TIDX, 32'h0000_0720);
    wr(ADDR_TDAT, 32'h0000_0121);
    wr(ADDR_TDAT, 32'h0000_0122);
    wr(ADDR_CTRL, 32'h4);
    pix_chk(px(1'b1, 1'b0, 8'h10, 8'h10, 8'h10), px(1'b1, 1'b0, 8'hff, 8'h10, 8'h10));
    src.put(px(1'b1, 1'b0, 8'h20, 8'h20, 8'h20), 1);
    repeat (7) @(posedge clk_sys);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys);
      #1;
      chk({31'h0, pix_out.c1 inside {8'h48, 8'h49}}, 32'h1);
      hi += (pix_out.c1 === 8'h49);
    end
    chk({31'h0, hi > 0 && hi < 32}, 32'h1);
    // Vsync clears the row phase, blanking clears the column phase
    wr(ADDR_CTRL, 32'hc);
    src.put(px(1'b0, 1'b1, 8'h21, 8'h21, 8'h21), 1);
    repeat (8) @(posedge clk_sys);
    src.put(px(1'b1, 1'b0, 8'h21, 8'h21, 8'h21), 1);
    repeat (5) @(posedge clk_sys);
    #1;
    chk({5'h00, pix_out}, {5'h00, px(1'b1, 1'b0, 8'h48, 8'h48, 8'h48)});
    @(posedge clk_sys);
    #1;
    chk({5'h00, pix_out}, {5'h00, px(1'b1, 1'b0, 8'h49, 8'h49, 8'h49)});
    wr(ADDR_CTRL, 32'h0);
    pix_chk(px(1'b1, 1'b0, 8'h21, 8'h21, 8'h21), px(1'b1, 1'b0, 8'h21, 8'h21, 8'h21));
    // One vsync rise so far, and the output is in active video
    rchk(ADDR_STAT, 32'h0001_0001, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // Clock, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    n_checks = 0;
    src.put('0, 0);
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_latency();
    t_rgb();
    t_chroma();
    t_table();
    report_and_stop();
  end

  // About three hundred cycles are needed; ten thousand is ample
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule // dca_color_pipe_test
